// file: rtl/pse_cfg_regs.sv
`default_nettype none
module pse_cfg_regs #(
    parameter logic [3:0] MAKER_CODE = pse_pkg::DEF_MAKER_CODE,
    parameter logic [3:0] CHIP_CODE = pse_pkg::DEF_CHIP_CODE
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Register port from the serial interface engine.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    // State reported by the port controller core.
    input wire logic [3:0] power_good,
    input wire logic [3:0] power_on,
    input wire logic [3:0] addr_strap,
    input wire logic quad_strap,
    input wire logic [3:0] auto_power_class_seen,
    input wire logic [3:0] link_check_result,
    input wire logic [7:0] temp_sample,
    input wire logic temp_sample_valid,
    // Configuration towards the core.
    output logic [7:0] port_operating_mode,
    output logic [7:0] unplug_sense_enable,
    output logic [7:0] probe_and_class_enable,
    output logic [7:0] priority_and_cut_inhibit,
    output logic [7:0] port_timing_select,
    output logic [7:0] general_control,
    output logic [31:0] two_pair_limits,
    output logic [7:0] logical_port_map,
    output logic [7:0] fine_priority_p1_p2,
    output logic [7:0] fine_priority_p3_p4,
    output logic [7:0] pair_power_budget,
    output logic [7:0] four_pair_limit_p12,
    output logic [7:0] four_pair_limit_p34,
    output logic [7:0] four_pair_fault_policy,
    // One-cycle command pulses towards the core.
    output logic [3:0] restart_class,
    output logic [3:0] restart_probe,
    output logic [3:0] turn_off_cmd,
    output logic [3:0] turn_on_cmd,
    output logic wipe_all_irqs,
    output logic clear_irq_pin,
    output logic reset_quad,
    output logic [3:0] reset_port
);
    import pse_pkg::*;

    // ******************************************************************
    // Helper functions.
    // ******************************************************************

    // Bits of each offset that software may change; zero elsewhere.
    function automatic logic [7:0] write_mask(input logic [7:0] a);
        logic [7:0] m;
        m = MASK_NONE;
        unique case (a)
            OFF_UNPLUG_SENSE_ENABLE: m = MASK_LOW_NIBBLE;
            OFF_GENERAL_CONTROL: m = MASK_GENERAL_CONTROL;
            OFF_FINE_PRIORITY_P1_P2, OFF_FINE_PRIORITY_P3_P4: m = MASK_FINE_PRIORITY;
            OFF_PORT_OPERATING_MODE, OFF_PROBE_AND_CLASS_ENABLE, OFF_PRIORITY_AND_CUT_INHIBIT,
            OFF_PORT_TIMING_SELECT, OFF_TWO_PAIR_LIMIT_P1, OFF_TWO_PAIR_LIMIT_P2,
            OFF_TWO_PAIR_LIMIT_P3, OFF_TWO_PAIR_LIMIT_P4, OFF_LOGICAL_PORT_MAP,
            OFF_PAIR_POWER_BUDGET, OFF_FOUR_PAIR_LIMIT_P12, OFF_FOUR_PAIR_LIMIT_P34,
            OFF_FOUR_PAIR_FAULT_POLICY: m = MASK_ALL;
            default: m = MASK_NONE;
        endcase
        return m;
    endfunction

    // Reset value of each stored offset.
    function automatic logic [7:0] reset_value(input logic [7:0] a);
        logic [7:0] v;
        v = RST_ZERO;
        unique case (a)
            OFF_UNPLUG_SENSE_ENABLE: v = RST_UNPLUG_SENSE_ENABLE;
            OFF_GENERAL_CONTROL: v = RST_GENERAL_CONTROL;
            OFF_TWO_PAIR_LIMIT_P1, OFF_TWO_PAIR_LIMIT_P2, OFF_TWO_PAIR_LIMIT_P3,
            OFF_TWO_PAIR_LIMIT_P4, OFF_FOUR_PAIR_LIMIT_P12,
            OFF_FOUR_PAIR_LIMIT_P34: v = RST_LIMIT;
            OFF_LOGICAL_PORT_MAP: v = RST_LOGICAL_PORT_MAP;
            OFF_FOUR_PAIR_FAULT_POLICY: v = RST_FOUR_PAIR_FAULT_POLICY;
            default: v = RST_ZERO;
        endcase
        return v;
    endfunction

    // True for a host write to a given offset.
    function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] off);
        return en && (a == off);
    endfunction

    // ******************************************************************
    // Storage.
    // ******************************************************************

    logic [7:0] cfg [OFF_FIRST:OFF_LAST];
    logic [7:0] power_state;
    logic [7:0] strap_state;
    logic [7:0] class_check_state;
    logic [7:0] die_temperature;
    logic in_range;

    assign in_range = (reg_addr >= OFF_FIRST) && (reg_addr <= OFF_LAST);

    // Stored settings; only masked bits move, so read-only, reserved and
    // command offsets never change here and unused bits stay zero.
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = OFF_FIRST; i <= OFF_LAST; i++) begin
                cfg[i] <= reset_value(8'(i));
            end
        end else if (reg_wr_en && in_range) begin
            cfg[reg_addr] <= (cfg[reg_addr] & ~write_mask(reg_addr)) | (reg_wr_data & write_mask(reg_addr));
        end
    end

    // Configuration outputs are the stored bytes themselves.
    assign port_operating_mode = cfg[OFF_PORT_OPERATING_MODE];
    assign unplug_sense_enable = cfg[OFF_UNPLUG_SENSE_ENABLE];
    assign probe_and_class_enable = cfg[OFF_PROBE_AND_CLASS_ENABLE];
    assign priority_and_cut_inhibit = cfg[OFF_PRIORITY_AND_CUT_INHIBIT];
    assign port_timing_select = cfg[OFF_PORT_TIMING_SELECT];
    assign general_control = cfg[OFF_GENERAL_CONTROL];
    assign two_pair_limits = {cfg[OFF_TWO_PAIR_LIMIT_P4], cfg[OFF_TWO_PAIR_LIMIT_P3],
                              cfg[OFF_TWO_PAIR_LIMIT_P2], cfg[OFF_TWO_PAIR_LIMIT_P1]};
    assign logical_port_map = cfg[OFF_LOGICAL_PORT_MAP];
    assign fine_priority_p1_p2 = cfg[OFF_FINE_PRIORITY_P1_P2];
    assign fine_priority_p3_p4 = cfg[OFF_FINE_PRIORITY_P3_P4];
    assign pair_power_budget = cfg[OFF_PAIR_POWER_BUDGET];
    assign four_pair_limit_p12 = cfg[OFF_FOUR_PAIR_LIMIT_P12];
    assign four_pair_limit_p34 = cfg[OFF_FOUR_PAIR_LIMIT_P34];
    assign four_pair_fault_policy = cfg[OFF_FOUR_PAIR_FAULT_POLICY];

    // ******************************************************************
    // Status capture.
    // ******************************************************************

    // Status is registered so a read sees a stable, single-cycle-old view.
    always_ff @(posedge mclk) begin
        if (srst) begin
            power_state <= RST_ZERO;
            strap_state <= RST_ZERO;
            class_check_state <= RST_ZERO;
        end else begin
            power_state <= {power_good, power_on};
            strap_state <= {1'b0, addr_strap, quad_strap, 2'b00};
            class_check_state <= {auto_power_class_seen, link_check_result};
        end
    end

    // The temperature holds the last completed measurement; it reads zero
    // until the first one, which software must treat as not yet valid.
    always_ff @(posedge mclk) begin
        if (srst) begin
            die_temperature <= RST_ZERO;
        end else if (temp_sample_valid) begin
            die_temperature <= temp_sample;
        end
    end

    // ******************************************************************
    // Command pulses.
    // ******************************************************************

    // Each one written acts exactly once; nothing is stored, so a repeat
    // of the same command needs a fresh write.
    always_ff @(posedge mclk) begin
        if (srst) begin
            restart_class <= '0;
            restart_probe <= '0;
            turn_off_cmd <= '0;
            turn_on_cmd <= '0;
            wipe_all_irqs <= 1'b0;
            clear_irq_pin <= 1'b0;
            reset_quad <= 1'b0;
            reset_port <= '0;
        end else begin
            if (wr_hit(reg_wr_en, reg_addr, OFF_RESTART_PROBE_CLASS_CMD)) begin
                {restart_class, restart_probe} <= reg_wr_data;
            end else begin
                {restart_class, restart_probe} <= '0;
            end
            if (wr_hit(reg_wr_en, reg_addr, OFF_PORT_POWER_ONOFF_CMD)) begin
                {turn_off_cmd, turn_on_cmd} <= reg_wr_data;
            end else begin
                {turn_off_cmd, turn_on_cmd} <= '0;
            end
            if (wr_hit(reg_wr_en, reg_addr, OFF_CLEAR_AND_RESET_CMD)) begin
                wipe_all_irqs <= reg_wr_data[CMD_WIPE_BIT];
                clear_irq_pin <= reg_wr_data[CMD_CLEAR_PIN_BIT];
                reset_quad <= reg_wr_data[CMD_QUAD_BIT];
                reset_port <= 4'(reg_wr_data);
            end else begin
                wipe_all_irqs <= 1'b0;
                clear_irq_pin <= 1'b0;
                reset_quad <= 1'b0;
                reset_port <= '0;
            end
        end
    end

    // ******************************************************************
    // Read path.
    // ******************************************************************

    // Read data is registered one cycle after the strobe and then held.
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rd_data <= RST_ZERO;
        end else if (reg_rd_en) begin
            unique case (reg_addr)
                OFF_PORT_POWER_STATE: reg_rd_data <= power_state;
                OFF_STRAP_PIN_STATE: reg_rd_data <= strap_state;
                OFF_MAKER_AND_CHIP_IDENT: reg_rd_data <= {MAKER_CODE, CHIP_CODE};
                OFF_AUTOCLASS_AND_LINK_CHECK: reg_rd_data <= class_check_state;
                OFF_DIE_TEMPERATURE: reg_rd_data <= die_temperature;
                default: begin
                    // Commands, reserved and unmapped offsets hold zero masks
                    // and zero contents, so they read zero.
                    if (in_range && (write_mask(reg_addr) != MASK_NONE)) begin
                        reg_rd_data <= cfg[reg_addr];
                    end else begin
                        reg_rd_data <= RST_ZERO;
                    end
                end
            endcase
        end
    end

    // ******************************************************************
    // Checks.
    // ******************************************************************

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    // Status reads are only compared once the capture register has seen a cycle out of reset.
    AST_POWER_READ: assert property (
        reg_rd_en && reg_addr == OFF_PORT_POWER_STATE && !$past(srst) ##1 1'b1
        |-> reg_rd_data == $past({power_good, power_on}, 2))
        else $error("power state read does not match inputs");

    AST_STRAP_READ: assert property (
        reg_rd_en && reg_addr == OFF_STRAP_PIN_STATE && !$past(srst) ##1 1'b1
        |-> reg_rd_data[7] == 1'b0 && reg_rd_data[1:0] == 2'b00 && reg_rd_data[6:3] == $past(addr_strap, 2)
        && reg_rd_data[2] == $past(quad_strap, 2))
        else $error("strap read wrong");

    AST_MODE_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_PORT_OPERATING_MODE |=> port_operating_mode == $past(reg_wr_data))
        else $error("mode write not stored");

    AST_UNPLUG_HIGH_ZERO: assert property (
        unplug_sense_enable[7:4] == 4'h0)
        else $error("unused disconnect bits set");

    AST_CONTROL_UNUSED_ZERO: assert property (
        general_control[5] == 1'b0 && general_control[1:0] == 2'b00)
        else $error("unused control bits set");

    AST_RESTART_PULSE: assert property (
        reg_wr_en && reg_addr == OFF_RESTART_PROBE_CLASS_CMD |=> {restart_class, restart_probe} == $past(reg_wr_data))
        else $error("restart command not issued");

    AST_RESTART_IDLE: assert property (
        !(reg_wr_en && reg_addr == OFF_RESTART_PROBE_CLASS_CMD) |=> {restart_class, restart_probe} == 8'h00)
        else $error("restart command pulse without a write");

    AST_POWER_CMD: assert property (
        reg_wr_en && reg_addr == OFF_PORT_POWER_ONOFF_CMD |=> {turn_off_cmd, turn_on_cmd} == $past(reg_wr_data))
        else $error("power command not issued");

    AST_CMD_READ_ZERO: assert property (
        reg_rd_en && (reg_addr == OFF_CLEAR_AND_RESET_CMD || reg_addr == OFF_RESERVED_1D) |=> reg_rd_data == 8'h00)
        else $error("command or reserved offset read nonzero");

    AST_FINE_UNUSED_ZERO: assert property (
        fine_priority_p1_p2[7] == 1'b0 && fine_priority_p1_p2[3] == 1'b0 &&
        fine_priority_p3_p4[7] == 1'b0 && fine_priority_p3_p4[3] == 1'b0)
        else $error("unused priority bits set");

    AST_TEMP_HOLD: assert property (
        !temp_sample_valid |=> $stable(die_temperature))
        else $error("temperature changed without a sample");

    AST_TEMP_TAKE: assert property (
        temp_sample_valid |=> die_temperature == $past(temp_sample))
        else $error("temperature sample not taken");

    // Pulses must vanish the cycle after any non-command cycle, or a core would act twice.
    AST_POWER_CMD_IDLE: assert property (
        !(reg_wr_en && reg_addr == OFF_PORT_POWER_ONOFF_CMD) |=> {turn_off_cmd, turn_on_cmd} == 8'h00)
        else $error("power command pulse without a write");

    // Bit 5 of the clear and reset byte has no command behind it.
    AST_CLEAR_CMD: assert property (
        reg_wr_en && reg_addr == OFF_CLEAR_AND_RESET_CMD |=>
        {wipe_all_irqs, clear_irq_pin, 1'b0, reset_quad, reset_port} == ($past(reg_wr_data) & 8'hdf))
        else $error("clear or reset command not issued");

    AST_CLEAR_IDLE: assert property (
        !(reg_wr_en && reg_addr == OFF_CLEAR_AND_RESET_CMD) |=>
        {wipe_all_irqs, clear_irq_pin, reset_quad, reset_port} == 7'h00)
        else $error("clear or reset pulse without a write");

    AST_UNPLUG_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_UNPLUG_SENSE_ENABLE |=>
        unplug_sense_enable == ($past(reg_wr_data) & MASK_LOW_NIBBLE))
        else $error("disconnect enable write not stored");

    AST_ENABLE_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_PROBE_AND_CLASS_ENABLE |=> probe_and_class_enable == $past(reg_wr_data))
        else $error("class and detect enable write not stored");

    AST_PRIORITY_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_PRIORITY_AND_CUT_INHIBIT |=> priority_and_cut_inhibit == $past(reg_wr_data))
        else $error("priority write not stored");

    AST_TIMING_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_PORT_TIMING_SELECT |=> port_timing_select == $past(reg_wr_data))
        else $error("timing write not stored");

    AST_CONTROL_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_GENERAL_CONTROL |=>
        general_control == ($past(reg_wr_data) & MASK_GENERAL_CONTROL))
        else $error("control write not stored");

    AST_IDENT_READ: assert property (
        reg_rd_en && reg_addr == OFF_MAKER_AND_CHIP_IDENT |=> reg_rd_data == {MAKER_CODE, CHIP_CODE})
        else $error("identification read wrong");

    AST_CLASS_READ: assert property (
        reg_rd_en && reg_addr == OFF_AUTOCLASS_AND_LINK_CHECK && !$past(srst) ##1 1'b1
        |-> reg_rd_data == $past({auto_power_class_seen, link_check_result}, 2))
        else $error("autoclass and link check read wrong");

    AST_LIMIT_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_TWO_PAIR_LIMIT_P4 |=> two_pair_limits[31:24] == $past(reg_wr_data))
        else $error("two-pair limit write not stored");

    AST_MAP_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_LOGICAL_PORT_MAP |=> logical_port_map == $past(reg_wr_data))
        else $error("port map write not stored");

    AST_FINE_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_FINE_PRIORITY_P3_P4 |=>
        fine_priority_p3_p4 == ($past(reg_wr_data) & MASK_FINE_PRIORITY))
        else $error("fine priority write not stored");

    AST_BUDGET_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_PAIR_POWER_BUDGET |=> pair_power_budget == $past(reg_wr_data))
        else $error("power budget write not stored");

    AST_FOUR_LIMIT_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_FOUR_PAIR_LIMIT_P34 |=> four_pair_limit_p34 == $past(reg_wr_data))
        else $error("four-pair limit write not stored");

    AST_POLICY_WRITE: assert property (
        reg_wr_en && reg_addr == OFF_FOUR_PAIR_FAULT_POLICY |=> four_pair_fault_policy == $past(reg_wr_data))
        else $error("fault policy write not stored");
endmodule
`default_nettype wire

// file: rtl/pse_pkg.sv
`default_nettype none
// ******************************************************************
// Register map of the port configuration and status bank.
// ******************************************************************
package pse_pkg;
    // Register offsets on the byte-wide register port.
    localparam logic [7:0] OFF_PORT_POWER_STATE = 8'h10;
    localparam logic [7:0] OFF_STRAP_PIN_STATE = 8'h11;
    localparam logic [7:0] OFF_PORT_OPERATING_MODE = 8'h12;
    localparam logic [7:0] OFF_UNPLUG_SENSE_ENABLE = 8'h13;
    localparam logic [7:0] OFF_PROBE_AND_CLASS_ENABLE = 8'h14;
    localparam logic [7:0] OFF_PRIORITY_AND_CUT_INHIBIT = 8'h15;
    localparam logic [7:0] OFF_PORT_TIMING_SELECT = 8'h16;
    localparam logic [7:0] OFF_GENERAL_CONTROL = 8'h17;
    localparam logic [7:0] OFF_RESTART_PROBE_CLASS_CMD = 8'h18;
    localparam logic [7:0] OFF_PORT_POWER_ONOFF_CMD = 8'h19;
    localparam logic [7:0] OFF_CLEAR_AND_RESET_CMD = 8'h1a;
    localparam logic [7:0] OFF_MAKER_AND_CHIP_IDENT = 8'h1b;
    localparam logic [7:0] OFF_AUTOCLASS_AND_LINK_CHECK = 8'h1c;
    localparam logic [7:0] OFF_RESERVED_1D = 8'h1d;
    localparam logic [7:0] OFF_TWO_PAIR_LIMIT_P1 = 8'h1e;
    localparam logic [7:0] OFF_TWO_PAIR_LIMIT_P2 = 8'h1f;
    localparam logic [7:0] OFF_TWO_PAIR_LIMIT_P3 = 8'h20;
    localparam logic [7:0] OFF_TWO_PAIR_LIMIT_P4 = 8'h21;
    localparam logic [7:0] OFF_LOGICAL_PORT_MAP = 8'h26;
    localparam logic [7:0] OFF_FINE_PRIORITY_P1_P2 = 8'h27;
    localparam logic [7:0] OFF_FINE_PRIORITY_P3_P4 = 8'h28;
    localparam logic [7:0] OFF_PAIR_POWER_BUDGET = 8'h29;
    localparam logic [7:0] OFF_FOUR_PAIR_LIMIT_P12 = 8'h2a;
    localparam logic [7:0] OFF_FOUR_PAIR_LIMIT_P34 = 8'h2b;
    localparam logic [7:0] OFF_DIE_TEMPERATURE = 8'h2c;
    localparam logic [7:0] OFF_FOUR_PAIR_FAULT_POLICY = 8'h2d;
    localparam logic [7:0] OFF_FIRST = 8'h10;
    localparam logic [7:0] OFF_LAST = 8'h2d;

    // Reset values.
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_UNPLUG_SENSE_ENABLE = 8'h0f;
    localparam logic [7:0] RST_GENERAL_CONTROL = 8'h80;
    localparam logic [7:0] RST_LIMIT = 8'hff;
    localparam logic [7:0] RST_LOGICAL_PORT_MAP = 8'he4;
    localparam logic [7:0] RST_FOUR_PAIR_FAULT_POLICY = 8'h0c;

    // Writable bit masks.
    localparam logic [7:0] MASK_ALL = 8'hff;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] MASK_LOW_NIBBLE = 8'h0f;
    localparam logic [7:0] MASK_GENERAL_CONTROL = 8'hdc;
    localparam logic [7:0] MASK_FINE_PRIORITY = 8'h77;

    // Bit positions inside the clear and reset command byte.
    localparam int CMD_WIPE_BIT = 7;
    localparam int CMD_CLEAR_PIN_BIT = 6;
    localparam int CMD_QUAD_BIT = 4;

    // Identification fields; the default values are arbitrary.
    localparam logic [3:0] DEF_MAKER_CODE = 4'h3;
    localparam logic [3:0] DEF_CHIP_CODE = 4'ha;
endpackage
`default_nettype wire

// file: testbench/pse_host_model.sv
`default_nettype none
// ************************************************************
// Host side of the register port: byte writes and reads.
// ************************************************************
module pse_host_model (
    // Clock.
    input wire logic mclk,
    // Register port towards the bank.
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus carries junk, never the last value, so stale data cannot pass a check.
    initial begin
        reg_addr = 8'hff;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'hff;
        reg_rd_en = 1'b0;
    end

    // One byte write; commands are issued this way as well.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge mclk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~d;
    endtask

    // One byte read; the data is taken the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = reg_rd_data;
    endtask
endmodule
`default_nettype wire

// file: testbench/poe_pse_config_status_regs_tb_top.sv
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module poe_pse_config_status_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pse_pkg::*;

    // ************************************************************
    // Signals.
    // ************************************************************
    logic mclk, srst, reg_wr_en, reg_rd_en, quad_strap, temp_sample_valid, wipe_all_irqs, clear_irq_pin, reset_quad;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, temp_sample, d;
    logic [3:0] power_good, power_on, addr_strap, auto_power_class_seen, link_check_result;
    logic [7:0] port_operating_mode, unplug_sense_enable, probe_and_class_enable, priority_and_cut_inhibit;
    logic [7:0] port_timing_select, general_control, logical_port_map, fine_priority_p1_p2, fine_priority_p3_p4;
    logic [7:0] pair_power_budget, four_pair_limit_p12, four_pair_limit_p34, four_pair_fault_policy;
    logic [31:0] two_pair_limits;
    logic [3:0] restart_class, restart_probe, turn_off_cmd, turn_on_cmd, reset_port;
    logic [31:0] pulses;
    int n_errors = 0;
    int tests_run = 0;
    // Rows: offset, value after reset, byte written, value read back afterwards.
    logic [31:0] rows [27] = '{
        32'h10_5a_ff_5a, 32'h11_4c_ff_4c, 32'h12_00_a5_a5, 32'h13_0f_ff_0f, 32'h14_00_c3_c3,
        32'h15_00_96_96, 32'h16_00_1b_1b, 32'h17_80_ff_dc, 32'h18_00_00_00, 32'h19_00_00_00,
        32'h1a_00_00_00, 32'h1b_3a_00_3a, 32'h1c_3c_ff_3c, 32'h1d_00_ff_00, 32'h1e_ff_12_12,
        32'h1f_ff_34_34, 32'h20_ff_56_56, 32'h21_ff_78_78, 32'h22_00_ff_00, 32'h26_e4_1b_1b,
        32'h27_00_ff_77, 32'h28_00_88_00, 32'h29_00_a5_a5, 32'h2a_ff_00_00, 32'h2b_ff_3c_3c,
        32'h2c_00_ff_00, 32'h2d_0c_f3_f3};

    // The command pulses gathered in the bit layout of their command bytes.
    assign pulses = {restart_class, restart_probe, turn_off_cmd, turn_on_cmd,
                     wipe_all_irqs, clear_irq_pin, 1'b0, reset_quad, reset_port, 8'h00};

    // ************************************************************
    // Clock, design and host.
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    pse_cfg_regs dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .power_good(power_good),
        .power_on(power_on), .addr_strap(addr_strap), .quad_strap(quad_strap),
        .auto_power_class_seen(auto_power_class_seen), .link_check_result(link_check_result),
        .temp_sample(temp_sample), .temp_sample_valid(temp_sample_valid), .port_operating_mode(port_operating_mode),
        .unplug_sense_enable(unplug_sense_enable), .probe_and_class_enable(probe_and_class_enable),
        .priority_and_cut_inhibit(priority_and_cut_inhibit), .port_timing_select(port_timing_select),
        .general_control(general_control), .two_pair_limits(two_pair_limits), .logical_port_map(logical_port_map),
        .fine_priority_p1_p2(fine_priority_p1_p2), .fine_priority_p3_p4(fine_priority_p3_p4),
        .pair_power_budget(pair_power_budget), .four_pair_limit_p12(four_pair_limit_p12),
        .four_pair_limit_p34(four_pair_limit_p34), .four_pair_fault_policy(four_pair_fault_policy),
        .restart_class(restart_class), .restart_probe(restart_probe), .turn_off_cmd(turn_off_cmd),
        .turn_on_cmd(turn_on_cmd), .wipe_all_irqs(wipe_all_irqs), .clear_irq_pin(clear_irq_pin),
        .reset_quad(reset_quad), .reset_port(reset_port));

    pse_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));

    // ************************************************************
    // Verdict and watchdog.
    // ************************************************************
    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles; this cuts a hang short.
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        results();
    end

    // ************************************************************
    // Stimulus.
    // ************************************************************
    initial begin
        srst = 1'b1;
        power_good = 4'h5;
        power_on = 4'ha;
        addr_strap = 4'h9;
        quad_strap = 1'b1;
        auto_power_class_seen = 4'h3;
        link_check_result = 4'hc;
        temp_sample = 8'h00;
        temp_sample_valid = 1'b0;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        // Reset value, then write and read back, for every offset of the table.
        foreach (rows[i]) begin
            host.rd(rows[i][31:24], d);
            `CHK(d, rows[i][23:16])
            host.wr(rows[i][31:24], rows[i][15:8]);
            host.rd(rows[i][31:24], d);
            `CHK(d, rows[i][7:0])
        end
        // Stored contents reach the core side as well.
        `CHK(two_pair_limits, 32'h78563412)
        `CHK({port_operating_mode, general_control, fine_priority_p1_p2}, 24'ha5dc77)
        `CHK({logical_port_map, pair_power_budget, four_pair_fault_policy}, 24'h1ba5f3)
        `CHK({four_pair_limit_p12, four_pair_limit_p34, port_timing_select}, 24'h003c1b)
        `CHK({probe_and_class_enable, priority_and_cut_inhibit, fine_priority_p3_p4}, 24'hc39600)
        // Each command byte gives a one-cycle pulse on exactly its own bits; bit 5 of 0x1a is unused.
        host.wr(OFF_RESTART_PROBE_CLASS_CMD, 8'ha5);
        `CHK(pulses, 32'ha5000000)
        @(negedge mclk);
        `CHK(pulses, 32'h00000000)
        host.wr(OFF_PORT_POWER_ONOFF_CMD, 8'h21);
        `CHK(pulses, 32'h00210000)
        @(negedge mclk);
        `CHK(pulses, 32'h00000000)
        host.wr(OFF_CLEAR_AND_RESET_CMD, 8'hff);
        `CHK(pulses, 32'h0000df00)
        @(negedge mclk);
        `CHK(pulses, 32'h00000000)
        // Temperature is taken only with its strobe.
        temp_sample = 8'h5e;
        temp_sample_valid = 1'b1;
        @(negedge mclk);
        temp_sample_valid = 1'b0;
        temp_sample = 8'h11;
        host.rd(OFF_DIE_TEMPERATURE, d);
        `CHK(d, 8'h5e)
        // Status follows the inputs after a change.
        power_good = 4'h8;
        power_on = 4'h1;
        @(negedge mclk);
        host.rd(OFF_PORT_POWER_STATE, d);
        `CHK(d, 8'h81)
        // A second reset in mid-run brings the stored values back.
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        `CHK({two_pair_limits, unplug_sense_enable}, 40'hffffffff0f)
        `CHK({port_operating_mode, four_pair_fault_policy, four_pair_limit_p12}, 24'h000cff)
        `CHK({probe_and_class_enable, priority_and_cut_inhibit, fine_priority_p3_p4}, 24'h000000)
        host.rd(OFF_GENERAL_CONTROL, d);
        `CHK(d, RST_GENERAL_CONTROL)
        host.rd(OFF_LOGICAL_PORT_MAP, d);
        `CHK(d, 8'he4)
        results();
    end
endmodule
`default_nettype wire
